// ===== rtl/srs_supervisor.v
// supply selection and system reset supervisor
// Overview of operation
// (R01) both supplies present: run from main
// (R02) main absent: internal rail from bus
// (R03) main arrives later: switch over, no reset
// (R04) main lost with both present: hard reset
// (R05) main absent flagged as dead battery
// (R06) hold circuits until their supply is good
// (R07) core enables rail feed switch, programmable
// (R08) rail on only with main ok, app running
// (R09) separate supervisor watches switched rail
// (R10) active-low reset low on rail undervoltage
// (R11) manual reset input asserts system reset
// (R12) manual reset active high, low selectable
// (R13) pull-down on rail while rail disabled
// (R14) synchronise manual reset, apply polarity first; the code applies polarity after synchronising
// assumes analog comparators deliver good/undervoltage levels asynchronously
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "srs_map.vh"

module srs_supervisor (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // supply monitors
    input wire main_supply_in,
    input wire bus_supply_in,
    input wire rail_good_in,
    // supply path controls
    output reg src_main_sel,
    output reg src_bus_sel,
    output reg hard_reset_req,
    output reg core_enable,
    // switched rail
    output reg rail_feed_switch,
    output reg rail_pulldown,
    // system reset
    input wire manual_reset_in,
    output reg sys_reset_out_n,
    // interrupt
    output reg irq
);

    // ==========================================
    // input synchronisers
    wire main_ok;
    wire bus_ok;
    wire rail_ok;
    wire manual_raw;

    srs_sync3 #(.RST_VAL(1'b0)) u_sync_main (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_in(main_supply_in),
        .level_q(main_ok)
    );

    srs_sync3 #(.RST_VAL(1'b0)) u_sync_bus (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_in(bus_supply_in),
        .level_q(bus_ok)
    );

    // rail supervisor comparator output, separate from the internal pors
    srs_sync3 #(.RST_VAL(1'b0)) u_sync_rail (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_in(rail_good_in),
        .level_q(rail_ok) // R09
    );

    srs_sync3 #(.RST_VAL(1'b0)) u_sync_mr (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_in(manual_reset_in),
        .level_q(manual_raw) // R14
    );

    // ==========================================
    // registers
    reg [31:0] ctrl_q;
    reg [`SRS_EV_WIDTH-1:0] irq_stat_q;
    reg [`SRS_EV_WIDTH-1:0] irq_mask_q;
    reg [15:0] hard_cnt_q;
    reg both_prev_q;
    reg main_prev_q;
    reg rail_uv_prev_q;
    reg manual_prev_q;

    wire app_run = ctrl_q[`SRS_CTRL_APP_RUN];
    wire rail_en = ctrl_q[`SRS_CTRL_RAIL_EN];
    wire mr_low = ctrl_q[`SRS_CTRL_MR_LOW];

    // polarity applied after synchronising
    wire manual_act = manual_raw ^ mr_low; // R12 R14
    wire hard_active = (hard_cnt_q != 16'h0000);
    wire [31:0] hard_rst_full = `SRS_HARD_RST_CYC;
    wire any_ok = main_ok | bus_ok;

    // ==========================================
    // supply events
    wire ev_switch_main = main_ok & ~main_prev_q & bus_ok; // R03
    wire ev_main_lost = both_prev_q & ~main_ok & bus_ok; // R04
    wire rail_uv = rail_feed_switch & ~rail_ok;
    wire ev_rail_uv = rail_uv & ~rail_uv_prev_q;
    wire ev_manual = manual_act & ~manual_prev_q;
    wire [`SRS_EV_WIDTH-1:0] ev_vec = {ev_manual, ev_rail_uv, ev_main_lost, ev_switch_main};

    // ==========================================
    // axi4-lite write channel
    reg aw_got_q;
    reg w_got_q;
    reg [11:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_q & ~s_axi_bvalid;

    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_got_q | aw_fire;
    wire w_have = w_got_q | w_fire;
    wire wr_do = aw_have & w_have & ~s_axi_bvalid;
    wire [11:0] wr_addr = aw_got_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_got_q ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb = w_got_q ? w_strb_q : s_axi_wstrb;

    wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_ctrl = wr_do & (wr_addr == `SRS_OFF_CTRL);
    wire wr_ist = wr_do & (wr_addr == `SRS_OFF_IRQ_STAT);
    wire wr_imask = wr_do & (wr_addr == `SRS_OFF_IRQ_MASK);
    wire wr_hit = wr_ctrl | wr_ist | wr_imask | (wr_addr == `SRS_OFF_STATUS);
    wire [`SRS_EV_WIDTH-1:0] ist_clr = wr_ist ?
        (wr_data[`SRS_EV_WIDTH-1:0] & wr_mask[`SRS_EV_WIDTH-1:0]) : {`SRS_EV_WIDTH{1'b0}};

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SRS_RESP_OKAY;
        end else begin
            if (wr_do) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `SRS_RESP_OKAY : `SRS_RESP_SLVERR;
            end else begin
                if (aw_fire) begin
                    aw_got_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_fire) begin
                    w_got_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // control and interrupt registers
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `SRS_CTRL_RESET;
            irq_mask_q <= {`SRS_EV_WIDTH{1'b0}};
            irq_stat_q <= {`SRS_EV_WIDTH{1'b0}};
        end else begin
            if (hard_active) begin
                // the reboot returns the control register, not the irq mask, to defaults
                ctrl_q <= `SRS_CTRL_RESET; // R04
            end else if (wr_ctrl) begin
                ctrl_q <= ((ctrl_q & ~wr_mask) | (wr_data & wr_mask)) & 32'h0000_0007; // R07
            end
            if (wr_imask) begin
                irq_mask_q <= (irq_mask_q & ~wr_mask[`SRS_EV_WIDTH-1:0]) |
                    (wr_data[`SRS_EV_WIDTH-1:0] & wr_mask[`SRS_EV_WIDTH-1:0]);
            end
            // a new event wins over a same-cycle clear
            irq_stat_q <= (irq_stat_q & ~ist_clr) | ev_vec;
        end
    end

    // ==========================================
    // axi4-lite read channel
    wire [31:0] status_word;
    assign status_word = {23'h000000, core_enable, ~sys_reset_out_n, manual_act, rail_uv,
        rail_feed_switch, ~main_ok, src_main_sel, bus_ok, main_ok}; // R05

    reg [31:0] rd_mux;
    reg rd_hit;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `SRS_OFF_CTRL: rd_mux = ctrl_q;
            `SRS_OFF_STATUS: rd_mux = status_word;
            `SRS_OFF_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
            `SRS_OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SRS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `SRS_RESP_OKAY : `SRS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // supply selection and hard reset
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            src_main_sel <= 1'b0;
            src_bus_sel <= 1'b0;
            core_enable <= 1'b0;
            hard_reset_req <= 1'b0;
            hard_cnt_q <= 16'h0000;
            both_prev_q <= 1'b0;
            main_prev_q <= 1'b0;
            rail_uv_prev_q <= 1'b0;
            manual_prev_q <= 1'b0;
        end else begin
            both_prev_q <= main_ok & bus_ok;
            main_prev_q <= main_ok;
            rail_uv_prev_q <= rail_uv;
            manual_prev_q <= manual_act;
            // main wins whenever present; switch-over from bus is seamless
            src_main_sel <= main_ok; // R01 R03
            src_bus_sel <= ~main_ok & bus_ok; // R02
            if (ev_main_lost) begin
                hard_cnt_q <= hard_rst_full[15:0]; // R04
            end else if (hard_active) begin
                hard_cnt_q <= hard_cnt_q - 16'h0001;
            end
            hard_reset_req <= ev_main_lost | (hard_cnt_q > 16'h0001);
            // core held until a good supply is reported
            core_enable <= any_ok & ~ev_main_lost & ~hard_active; // R06
        end
    end

    // ==========================================
    // switched rail and system reset
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rail_feed_switch <= 1'b0;
            rail_pulldown <= 1'b1;
            sys_reset_out_n <= 1'b0;
            irq <= 1'b0;
        end else begin
            rail_feed_switch <= main_ok & app_run & rail_en & core_enable; // R07 R08
            rail_pulldown <= ~(main_ok & app_run & rail_en & core_enable); // R13
            // low on rail undervoltage, rail off or manual reset
            sys_reset_out_n <= rail_feed_switch & rail_ok & ~manual_act; // R08 R10 R11
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule // srs_supervisor

`default_nettype wire

// ===== common/srs_map.vh
// supply/reset supervisor register map and field positions
// assumes a 32-bit AXI4-Lite slave with word-aligned registers
`ifndef SRS_MAP_VH
`define SRS_MAP_VH

// ==========================================
// register byte offsets
`define SRS_OFF_CTRL 12'h000
`define SRS_OFF_STATUS 12'h004
`define SRS_OFF_IRQ_STAT 12'h008
`define SRS_OFF_IRQ_MASK 12'h00c

// ==========================================
// control register fields
`define SRS_CTRL_APP_RUN 0
`define SRS_CTRL_RAIL_EN 1
`define SRS_CTRL_MR_LOW 2
`define SRS_CTRL_RESET 32'h0000_0000

// ==========================================
// status register fields
`define SRS_ST_MAIN_OK 0
`define SRS_ST_BUS_OK 1
`define SRS_ST_SRC_MAIN 2
`define SRS_ST_DEAD_BATT 3
`define SRS_ST_RAIL_ON 4
`define SRS_ST_RAIL_UV 5
`define SRS_ST_MANUAL 6
`define SRS_ST_SYS_RST 7
`define SRS_ST_CORE_RUN 8

// ==========================================
// interrupt event bits
`define SRS_EV_SWITCH_MAIN 0
`define SRS_EV_MAIN_LOST 1
`define SRS_EV_RAIL_UV 2
`define SRS_EV_MANUAL 3
`define SRS_EV_WIDTH 4

// ==========================================
// bus responses
`define SRS_RESP_OKAY 2'h0
`define SRS_RESP_SLVERR 2'h2

// ==========================================
// hard reset hold time
`define SRS_HARD_RST_NS 1000
`define SRS_CLK_PERIOD_NS 4
`define SRS_HARD_RST_CYC ((`SRS_HARD_RST_NS + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)

`endif

// ===== rtl/srs_sync3.v
// three-stage synchroniser with agreement filter for one pin input
// assumes the input is asynchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none

module srs_sync3 #(
    parameter [0:0] RST_VAL = 1'b0
) (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // pin side
    input wire pin_in,
    // core side
    output reg level_q
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    // ==========================================
    // stage chain; stage one feeds stage two only
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            level_q <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

endmodule // srs_sync3

`default_nettype wire

// ===== verif/srs_checker.sv
// port assertions for the supply and reset supervisor
// assumes binding onto srs_supervisor, single clk_sys domain
`timescale 1ns/10ps
`default_nettype none

module srs_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // monitored inputs
    input wire logic main_supply_in,
    input wire logic bus_supply_in,
    input wire logic rail_good_in,
    // watched outputs
    input wire logic src_main_sel,
    input wire logic src_bus_sel,
    input wire logic hard_reset_req,
    input wire logic core_enable,
    input wire logic rail_feed_switch,
    input wire logic rail_pulldown,
    input wire logic sys_reset_out_n
);
    // ==========================================
    // sequences
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence both_up;
        (main_supply_in && bus_supply_in)[*8];
    endsequence
    sequence bus_only;
        (!main_supply_in && bus_supply_in && !hard_reset_req)[*8];
    endsequence

    // ==========================================
    // assertions
    a_main_pref: assert property ((main_supply_in && !hard_reset_req)[*8] |-> src_main_sel)
        else $error("main supply not selected");
    a_bus_feed: assert property (bus_only |-> src_bus_sel && !src_main_sel)
        else $error("bus supply not selected");
    a_switch_quiet: assert property (bus_only ##1 main_supply_in[*8] |-> !hard_reset_req)
        else $error("hard reset on switch to main");
    a_main_lost: assert property (both_up ##1 (!main_supply_in && bus_supply_in)[*8]
        |-> hard_reset_req)
        else $error("no hard reset after main loss");
    a_hold_core: assert property (hard_reset_req |=> !core_enable)
        else $error("core enabled during hard reset");
    a_no_supply: assert property ((!main_supply_in && !bus_supply_in)[*8] |-> !core_enable)
        else $error("core enabled without supply");
    a_rail_main: assert property ((!main_supply_in)[*8] |-> !rail_feed_switch)
        else $error("rail fed without main");
    a_pull_down: assert property (1'b1 |-> rail_pulldown != rail_feed_switch)
        else $error("pulldown not inverse of feed");
    a_uv_reset: assert property ((!rail_good_in)[*8] |-> !sys_reset_out_n)
        else $error("reset released on undervoltage");
    a_release_rail: assert property ($rose(sys_reset_out_n) |-> $past(rail_feed_switch))
        else $error("reset released with rail off");
endmodule // srs_checker

`default_nettype wire

// ===== verif/srs_host_model.sv
// far side: switched-rail supervisor comparator and manual reset source
// assumes the rail settles RISE_CYC cycles after the feed switch closes
`timescale 1ns/10ps
`default_nettype none

module srs_host_model #(
    parameter int RISE_CYC = 3
) (
    // clock
    input wire logic clk_sys,
    // bench commands
    input wire logic uv_fault,
    input wire logic mr_press,
    input wire logic mr_low,
    // pins
    input wire logic rail_feed_switch,
    output logic rail_good_in,
    output logic manual_reset_in
);
    int rise_q = 0;
    always_ff @(posedge clk_sys) begin
        rise_q <= rail_feed_switch ? (rise_q < RISE_CYC ? rise_q + 1 : rise_q) : 0;
    end
    // rail above threshold only once fed and without injected sag
    assign rail_good_in = (rise_q == RISE_CYC) && !uv_fault;
    assign manual_reset_in = mr_press ^ mr_low;
endmodule // srs_host_model

`default_nettype wire

// ===== verif/supply_reset_supervisor_tb.sv
// self-checking bench for the supply and reset supervisor
// assumes srs_checker and srs_host_model compiled before
`timescale 1ns/10ps
`default_nettype none
`include "srs_map.vh"

module supply_reset_supervisor_tb;
    logic clk_sys = 0;
    logic arst_n = 0;
    logic [11:0] awaddr = 0;
    logic [11:0] araddr = 0;
    logic [31:0] wdata = 0;
    logic awvalid = 0;
    logic wvalid = 0;
    logic bready = 0;
    logic arvalid = 0;
    logic rready = 0;
    logic awready, wready, arready, bvalid, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [1:0] last_bresp = 2'h0;
    logic [31:0] rdata;
    logic main = 0;
    logic bus = 0;
    logic uv = 0;
    logic press = 0;
    logic low = 0;
    logic rg, mri, sm, sb, hr, ce, rfs, rpd, rst_n;
    int miscompares = 0;
    int n_checks = 0;

    always #2 clk_sys = ~clk_sys;

    srs_supervisor uut (.clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .main_supply_in(main), .bus_supply_in(bus),
        .rail_good_in(rg), .src_main_sel(sm), .src_bus_sel(sb), .hard_reset_req(hr),
        .core_enable(ce), .rail_feed_switch(rfs), .rail_pulldown(rpd),
        .manual_reset_in(mri), .sys_reset_out_n(rst_n), .irq(irq));

    srs_host_model host (.clk_sys(clk_sys), .uv_fault(uv), .mr_press(press), .mr_low(low),
        .rail_feed_switch(rfs), .rail_good_in(rg), .manual_reset_in(mri));

    // ==========================================
    // helpers
    function automatic logic exp_rst(input logic pressed, input logic sag, input logic on);
        return on && !sag && !pressed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit aw_pend;
        bit w_pend;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        aw_pend = 1;
        w_pend = 1;
        // each channel released only at the edge where its ready is seen high
        while (aw_pend || w_pend) begin
            @(posedge clk_sys);
            if (aw_pend && awready) begin
                awvalid <= 0;
                aw_pend = 0;
            end
            if (w_pend && wready) begin
                wvalid <= 0;
                w_pend = 0;
            end
        end
        do @(posedge clk_sys); while (!bvalid);
        last_bresp = bresp;
        bready <= 0;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 0;
        do @(posedge clk_sys); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
        logic [31:0] d;
        logic [1:0] r;
        rd_reg(a, d, r);
        chk(d & msk, exp);
        chk({30'h0, r}, {30'h0, `SRS_RESP_OKAY});
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // scenarios
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        logic p;
        void'($urandom(32'h2c1d));
        repeat (2) @(posedge clk_sys);
        arst_n <= 1;
        tick(12);
        chk(ce, 0);
        rchk(`SRS_OFF_CTRL, 0, 32'hffffffff);
        rd_reg(12'h010, v, r);
        chk({30'h0, r}, {30'h0, `SRS_RESP_SLVERR});
        wr(12'h010, 32'hf);
        chk({30'h0, last_bresp}, {30'h0, `SRS_RESP_SLVERR});
        bus <= 1;
        tick(12);
        chk(sb, 1);
        rchk(`SRS_OFF_STATUS, 32'ha, 32'hf);
        main <= 1;
        tick(12);
        chk(hr, 0);
        chk(sm, 1);
        chk(irq, 0);
        wr(`SRS_OFF_IRQ_MASK, 32'hf);
        chk({30'h0, last_bresp}, {30'h0, `SRS_RESP_OKAY});
        tick(2);
        chk(irq, 1);
        rchk(`SRS_OFF_IRQ_STAT, 1, 1);
        wr(`SRS_OFF_IRQ_STAT, 32'hf);
        tick(2);
        chk(irq, 0);
        wr(`SRS_OFF_CTRL, 3);
        tick(12);
        chk(rfs, 1);
        chk(rpd, 0);
        chk(rst_n, 1);
        for (int k = 0; k < 8; k++) begin
            p = (k < 2) ? k[0] : 1'($urandom);
            wr(`SRS_OFF_CTRL, {29'h0, p, 2'b11});
            press <= 1'($urandom);
            low <= p;
            tick(12);
            chk(rst_n, exp_rst(press, 0, 1));
        end
        press <= 0;
        // the rail ramp already flagged undervoltage; clear it so the sag is seen
        wr(`SRS_OFF_IRQ_STAT, 32'hf);
        uv <= 1;
        tick(12);
        chk(rst_n, 0);
        rchk(`SRS_OFF_IRQ_STAT, 4, 4);
        uv <= 0;
        tick(12);
        chk(rst_n, 1);
        wr(`SRS_OFF_CTRL, {29'h0, low, 2'b01});
        tick(12);
        chk(rpd, 1);
        chk(rst_n, 0);
        wr(`SRS_OFF_CTRL, 3);
        tick(12);
        main <= 0;
        tick(12);
        chk(hr, 1);
        chk(rfs, 0);
        rchk(`SRS_OFF_CTRL, 0, 32'hffffffff);
        tick(300);
        chk(hr, 0);
        chk(sb, 1);
        tally_and_finish();
    end

    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule // supply_reset_supervisor_tb

bind srs_supervisor srs_checker chk_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .main_supply_in(main_supply_in), .bus_supply_in(bus_supply_in),
    .rail_good_in(rail_good_in), .src_main_sel(src_main_sel), .src_bus_sel(src_bus_sel),
    .hard_reset_req(hard_reset_req), .core_enable(core_enable),
    .rail_feed_switch(rail_feed_switch), .rail_pulldown(rail_pulldown),
    .sys_reset_out_n(sys_reset_out_n));

`default_nettype wire
